// ### design/tcc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"
// Function
// - Capture source: pin or masked radio events
// - Interrupt mask resets to 1, gates request
// - Mode bit selects capture or compare, reset 0
// - Edge field selects none, rise, fall, both
// - Actions set, clear, toggle on match
// - Set on up match, clear at zero (on down match in up/down mode)
// - Clear on up match, set at zero (on down match in up/down mode)
// - Channel 1: set own, clear ch0 match
// - Channel 1: clear own, set ch0 match
// - Action 111 on ch1 is modulator, speed bit
// - Edge field configures interpolator and shaping
// - Channel 0 value is modulator rate
// - Channel 1 value pair is sample data
// - Value bytes readable, writable, reset zero
// - Up/down match direction follows counter direction
module tcc_top (
  // Clock and reset
  input  wire        clock,
  input  wire        resetn,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata_r,
  // Timer counter
  input  wire [15:0] timer_count,
  input  wire        timer_tick,
  input  wire        timer_down,
  input  wire        timer_updown,
  // Capture sources
  input  wire [1:0]  capture_pin,
  input  wire [7:0]  radio_event,
  // Outputs to pins and interrupt logic
  output reg  [1:0]  chan_out_r,
  output reg  [1:0]  chan_irq_r,
  // Modulator
  output reg         mod_sample_strobe_r,
  output reg  [15:0] mod_sample_r,
  output reg  [15:0] mod_rate_r,
  output reg         mod_interp_en_r,
  output reg         mod_shaping_en_r,
  output reg         mod_active_r
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  reg  [1:0]  rst_sync_r;       // Reset release synchroniser
  wire        rst_n;            // Synchronised reset used everywhere
  reg  [7:0]  ctrl_r [0:1];     // Per channel control
  reg  [7:0]  val_lo_r [0:1];   // Value low bytes
  reg  [7:0]  val_hi_r [0:1];   // Value high bytes
  reg  [7:0]  radio_mask_r;     // Radio event mask
  reg         lo_pending_r;     // Low sample byte written, high not yet
  reg  [2:0]  mod_div_r;        // Modulator rate divider
  wire [15:0] val0;             // Channel 0 full value
  wire        mod_mode;         // Channel 1 in modulator mode
  wire        radio_hit;        // Any enabled radio event
  wire [1:0]  cap_evt;          // Capture event per channel
  wire [1:0]  match;            // Counter equals value per channel
  wire [1:0]  out_nxt;          // Output from action logic
  wire        at_zero;          // Counter at zero on a tick
  reg  [7:0]  rdata_nxt;        // Read mux result

  // ----------------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------------
  // Shared decode
  // ----------------------------------------------------------------------
  assign val0     = {val_hi_r[0], val_lo_r[0]};
  assign mod_mode = (ctrl_r[1][`TCC_ACT_HI:`TCC_ACT_LO] == `TCC_ACT_MOD);
  assign radio_hit = |(radio_event & radio_mask_r);
  assign at_zero  = timer_tick & (timer_count == 16'h0000);

  // ----------------------------------------------------------------------
  // Per channel capture and compare
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
      // Capture only in capture mode; modulator owns channel 1 fields
      tcc_capture u_cap (
        .clock     (clock),
        .rst_n     (rst_n),
        .src_sel   (ctrl_r[gi][`TCC_SRC_BIT]),
        .edge_sel  (ctrl_r[gi][`TCC_EDGE_HI:`TCC_EDGE_LO]),
        .enable    (~ctrl_r[gi][`TCC_MODE_BIT] & ~(gi == 1 && mod_mode)),
        .pin_in    (capture_pin[gi]),
        .radio_hit (radio_hit),
        .capture   (cap_evt[gi])
      );

      assign match[gi] = timer_tick & (timer_count == {val_hi_r[gi], val_lo_r[gi]});

      // Compare logic acts only with the mode bit set
      tcc_output u_out (
        .clock         (clock),
        .rst_n         (rst_n),
        .enable        (ctrl_r[gi][`TCC_MODE_BIT]),
        .action        (ctrl_r[gi][`TCC_ACT_HI:`TCC_ACT_LO]),
        .allow_ch0     (gi == 1),
        .own_match     (match[gi]),
        .ch0_match     (match[0]),
        .at_zero       (at_zero),
        .counting_down (timer_down),
        .updown        (timer_updown),
        .out_r         (out_nxt[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Register writes and captures
  // ----------------------------------------------------------------------
  // A capture in the same cycle as a software value write wins, so the
  // captured count is never lost to a racing write.
  integer i;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 2; i = i + 1) begin
        ctrl_r[i]   <= `TCC_CTRL_RESET;
        val_lo_r[i] <= `TCC_VAL_RESET;
        val_hi_r[i] <= `TCC_VAL_RESET;
      end
      radio_mask_r <= `TCC_RMASK_RESET;
    end else begin
      if (reg_write) begin
        case (reg_addr)
          `TCC_ADDR_CH0_VAL_LOW:  val_lo_r[0]  <= reg_wdata;
          `TCC_ADDR_CH0_VAL_HIGH: val_hi_r[0]  <= reg_wdata;
          `TCC_ADDR_CH1_VAL_LOW:  val_lo_r[1]  <= reg_wdata;
          `TCC_ADDR_CH1_VAL_HIGH: val_hi_r[1]  <= reg_wdata;
          `TCC_ADDR_CH0_CTRL:     ctrl_r[0]    <= reg_wdata;
          `TCC_ADDR_CH1_CTRL:     ctrl_r[1]    <= reg_wdata;
          `TCC_ADDR_RADIO_MASK:   radio_mask_r <= reg_wdata;
          default: ;                                           // Unmapped: ignored
        endcase
      end
      for (i = 0; i < 2; i = i + 1) begin
        if (cap_evt[i]) begin
          val_lo_r[i] <= timer_count[7:0];
          val_hi_r[i] <= timer_count[15:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read port: data one cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------------
  always @* begin
    case (reg_addr)
      `TCC_ADDR_CH0_VAL_LOW:  rdata_nxt = val_lo_r[0];
      `TCC_ADDR_CH0_VAL_HIGH: rdata_nxt = val_hi_r[0];
      `TCC_ADDR_CH1_VAL_LOW:  rdata_nxt = val_lo_r[1];
      `TCC_ADDR_CH1_VAL_HIGH: rdata_nxt = val_hi_r[1];
      `TCC_ADDR_CH0_CTRL:     rdata_nxt = ctrl_r[0];
      `TCC_ADDR_CH1_CTRL:     rdata_nxt = ctrl_r[1];
      `TCC_ADDR_RADIO_MASK:   rdata_nxt = radio_mask_r;
      `TCC_ADDR_STATUS:       rdata_nxt = {3'h0, mod_active_r, chan_irq_r, chan_out_r};
      default:                rdata_nxt = 8'h00;   // Unmapped reads as zero
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
    end else begin
      reg_rdata_r <= reg_read ? rdata_nxt : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt requests and pin outputs
  // ----------------------------------------------------------------------
  // One-cycle request per channel event, gated by the channel mask.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chan_irq_r <= 2'h0;
      chan_out_r <= 2'h0;
    end else begin
      chan_out_r    <= out_nxt;
      chan_irq_r[0] <= ctrl_r[0][`TCC_IRQ_MASK_BIT] & (cap_evt[0] |
                       (ctrl_r[0][`TCC_MODE_BIT] & match[0]));
      chan_irq_r[1] <= ctrl_r[1][`TCC_IRQ_MASK_BIT] & (cap_evt[1] |
                       (ctrl_r[1][`TCC_MODE_BIT] & match[1] & ~mod_mode));
    end
  end

  // ----------------------------------------------------------------------
  // Modulator sample path
  // ----------------------------------------------------------------------
  // The sample is taken only once the high byte follows the low byte, so
  // a half-written sample never reaches the modulator. The two lowest bits
  // are forced to zero, leaving 14 effective bits.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lo_pending_r        <= 1'b0;
      mod_sample_r        <= 16'h0000;
      mod_sample_strobe_r <= 1'b0;
    end else begin
      mod_sample_strobe_r <= 1'b0;
      if (reg_write && reg_addr == `TCC_ADDR_CH1_VAL_LOW) begin
        lo_pending_r <= 1'b1;
      end else if (reg_write && reg_addr == `TCC_ADDR_CH1_VAL_HIGH) begin
        lo_pending_r <= 1'b0;
        if (mod_mode && lo_pending_r) begin
          mod_sample_r        <= {reg_wdata, val_lo_r[1][7:2], 2'h0};
          mod_sample_strobe_r <= 1'b1;
        end
      end
    end
  end

  // Rate, configuration and sample clock of the modulator. The sample
  // clock is the tick divided by 8 or 4 as the speed bit asks.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mod_rate_r       <= 16'h0000;
      mod_interp_en_r  <= 1'b0;
      mod_shaping_en_r <= 1'b0;
      mod_active_r     <= 1'b0;
      mod_div_r        <= 3'h0;
    end else begin
      mod_rate_r       <= val0;
      mod_interp_en_r  <= mod_mode & ~ctrl_r[1][1];
      mod_shaping_en_r <= mod_mode & ~ctrl_r[1][0];
      if (!mod_mode) begin
        mod_active_r <= 1'b0;
        mod_div_r    <= 3'h0;
      end else if (timer_tick) begin
        // Active marks each modulator step at the chosen speed
        if (mod_div_r >= (ctrl_r[1][`TCC_MODE_BIT] ? `TCC_MOD_DIV_FAST
                                                   : `TCC_MOD_DIV_SLOW)) begin
          mod_div_r    <= 3'h0;
          mod_active_r <= 1'b1;
        end else begin
          mod_div_r    <= mod_div_r + 3'h1;
          mod_active_r <= 1'b0;
        end
      end else begin
        mod_active_r <= 1'b0;
      end
    end
  end

endmodule // tcc_top
`default_nettype wire

// ### design/tcc_regs.vh
`ifndef TCC_REGS_VH
`define TCC_REGS_VH
// ----------------------------------------------------------------------
// Register offsets (byte addresses on the 8-bit register port)
// ----------------------------------------------------------------------
`define TCC_ADDR_CH0_VAL_LOW   8'hDA
`define TCC_ADDR_CH0_VAL_HIGH  8'hDB
`define TCC_ADDR_CH1_VAL_LOW   8'hDC
`define TCC_ADDR_CH1_VAL_HIGH  8'hDD
`define TCC_ADDR_CH0_CTRL      8'hE5
`define TCC_ADDR_CH1_CTRL      8'hE6
`define TCC_ADDR_RADIO_MASK    8'hE8
`define TCC_ADDR_STATUS        8'hE9
// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define TCC_SRC_BIT            7
`define TCC_IRQ_MASK_BIT       6
`define TCC_ACT_HI             5
`define TCC_ACT_LO             3
`define TCC_MODE_BIT           2
`define TCC_EDGE_HI            1
`define TCC_EDGE_LO            0
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TCC_CTRL_RESET         8'h40
`define TCC_VAL_RESET          8'h00
`define TCC_RMASK_RESET        8'h00
// ----------------------------------------------------------------------
// Compare action codes
// ----------------------------------------------------------------------
`define TCC_ACT_SET            3'h0
`define TCC_ACT_CLR            3'h1
`define TCC_ACT_TOG            3'h2
`define TCC_ACT_SETUP          3'h3
`define TCC_ACT_CLRUP          3'h4
`define TCC_ACT_SET_CH0CLR     3'h5
`define TCC_ACT_CLR_CH0SET     3'h6
`define TCC_ACT_MOD            3'h7
// ----------------------------------------------------------------------
// Capture edge codes
// ----------------------------------------------------------------------
`define TCC_EDGE_NONE          2'h0
`define TCC_EDGE_RISE          2'h1
`define TCC_EDGE_FALL          2'h2
`define TCC_EDGE_BOTH          2'h3
// ----------------------------------------------------------------------
// Modulator rate dividers in timer ticks
// ----------------------------------------------------------------------
`define TCC_MOD_DIV_SLOW       3'h7
`define TCC_MOD_DIV_FAST       3'h3
`endif

// ### design/tcc_capture.v
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"
// ----------------------------------------------------------------------
// Capture trigger detector for one channel
// ----------------------------------------------------------------------
module tcc_capture (
  // Clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // Configuration
  input  wire       src_sel,
  input  wire [1:0] edge_sel,
  input  wire       enable,
  // Sources
  input  wire       pin_in,
  input  wire       radio_hit,
  // Result
  output wire       capture
);
  reg  pin_prev_r;   // Previous pin sample for edge detection
  wire rise;         // Rising edge seen on the pin
  wire fall;         // Falling edge seen on the pin
  reg  pin_trig;     // Pin trigger after edge selection

  // ----------------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin_in;
    end
  end

  assign rise = pin_in & ~pin_prev_r;
  assign fall = ~pin_in & pin_prev_r;

  // Edge selection; code none blocks every pin trigger
  always @* begin
    case (edge_sel)
      `TCC_EDGE_RISE: pin_trig = rise;
      `TCC_EDGE_FALL: pin_trig = fall;
      `TCC_EDGE_BOTH: pin_trig = rise | fall;
      default:        pin_trig = 1'b0;
    endcase
  end

  // Radio events bypass the pin edge logic when selected
  assign capture = enable & (src_sel ? radio_hit : pin_trig);
endmodule // tcc_capture
`default_nettype wire

// ### design/tcc_output.v
`timescale 1ns/1ps
`default_nettype none
`include "tcc_regs.vh"
// ----------------------------------------------------------------------
// Compare output action for one channel
// ----------------------------------------------------------------------
module tcc_output (
  // Clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // Configuration
  input  wire       enable,
  input  wire [2:0] action,
  input  wire       allow_ch0,
  // Counter events
  input  wire       own_match,
  input  wire       ch0_match,
  input  wire       at_zero,
  input  wire       counting_down,
  input  wire       updown,
  // Result
  output reg        out_r
);
  reg out_nxt;  // Next output level

  // ----------------------------------------------------------------------
  // Action decode
  // ----------------------------------------------------------------------
  always @* begin
    out_nxt = out_r;
    if (enable) begin
      case (action)
        `TCC_ACT_SET: if (own_match) out_nxt = 1'b1;
        `TCC_ACT_CLR: if (own_match) out_nxt = 1'b0;
        `TCC_ACT_TOG: if (own_match) out_nxt = ~out_r;
        `TCC_ACT_SETUP: begin
          // Up/down mode swaps the zero event for the down match
          if (own_match && !counting_down) out_nxt = 1'b1;
          else if (updown ? (own_match && counting_down) : at_zero)
            out_nxt = 1'b0;
        end
        `TCC_ACT_CLRUP: begin
          if (own_match && !counting_down) out_nxt = 1'b0;
          else if (updown ? (own_match && counting_down) : at_zero)
            out_nxt = 1'b1;
        end
        `TCC_ACT_SET_CH0CLR: if (allow_ch0) begin
          if (own_match) out_nxt = 1'b1;
          else if (ch0_match) out_nxt = 1'b0;
        end
        `TCC_ACT_CLR_CH0SET: if (allow_ch0) begin
          if (own_match) out_nxt = 1'b0;
          else if (ch0_match) out_nxt = 1'b1;
        end
        // Reserved on channel 0, modulator on channel 1: hold
        default: out_nxt = out_r;
      endcase
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
    end
  end
endmodule // tcc_output
`default_nettype wire

// ### tb/tcc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------
// Port checks for the capture/compare block
// ----------------------------------------------------------
module tcc_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        resetn,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata_r,
  // Timer and channel outputs
  input wire logic        timer_tick,
  input wire logic [1:0]  chan_out_r,
  input wire logic [1:0]  chan_irq_r,
  // Modulator
  input wire logic        mod_sample_strobe_r,
  input wire logic [15:0] mod_sample_r,
  input wire logic        mod_interp_en_r,
  input wire logic        mod_shaping_en_r,
  input wire logic        mod_active_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Offsets that decode; all others must read as zero
  wire mapped = reg_addr inside {8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hE5, 8'hE6, 8'hE8, 8'hE9};
  a_rdata_idle: assert property (!reg_read |=> reg_rdata_r == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (reg_read && !mapped |=> reg_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  a_value_readback: assert property (reg_write && reg_addr == 8'hDB ##2
    reg_read && reg_addr == 8'hDB |=> reg_rdata_r == $past(reg_wdata, 3))
    else $error("value byte readback wrong");
  a_irq_single: assert property (chan_irq_r != 2'b00
    |=> (chan_irq_r & $past(chan_irq_r)) == 2'b00)
    else $error("request longer than one cycle");
  a_out_after_tick: assert property ($changed(chan_out_r) |-> $past(timer_tick, 2))
    else $error("output moved without a tick");
  a_sample_cause: assert property (mod_sample_strobe_r
    |-> $past(reg_write) && $past(reg_addr) == 8'hDD)
    else $error("sample strobe without high byte write");
  a_sample_value: assert property (mod_sample_strobe_r |=>
    mod_sample_r[15:8] == $past(reg_wdata, 2) && mod_sample_r[1:0] == 2'b00)
    else $error("sample value wrong");
  a_mod_config: assert property (reg_write && reg_addr == 8'hE6 && reg_wdata[5:3] == 3'h7
    |-> ##2 mod_interp_en_r == !$past(reg_wdata[1], 2) && mod_shaping_en_r == !$past(reg_wdata[0], 2))
    else $error("modulator config wrong");
  a_mod_spacing: assert property (mod_active_r |=> !mod_active_r [*3])
    else $error("modulator steps too close");
  // Main scenarios reached
  c_sample: cover property (mod_sample_strobe_r);
  c_capture: cover property (chan_irq_r[0]);
  c_out_rise: cover property ($rose(chan_out_r[1]));
endmodule  // tcc_checker
bind tcc_top tcc_checker tcc_checker_i (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata_r(reg_rdata_r), .timer_tick(timer_tick), .chan_out_r(chan_out_r),
  .chan_irq_r(chan_irq_r), .mod_sample_strobe_r(mod_sample_strobe_r),
  .mod_sample_r(mod_sample_r), .mod_interp_en_r(mod_interp_en_r),
  .mod_shaping_en_r(mod_shaping_en_r), .mod_active_r(mod_active_r));
`default_nettype wire

// ### tb/tcc_timer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------
// Timer counter on the far side of the channels
// ----------------------------------------------------------
module tcc_timer_model (
  // Control from the bench
  input  wire logic        clock,
  input  wire logic        run,
  input  wire logic        clr,
  input  wire logic        updown,
  input  wire logic [15:0] top,
  // Counter outputs
  output var  logic [15:0] count = 16'h0000,
  output var  logic        tick = 1'b0,
  output var  logic        down = 1'b0,
  output var  logic        mode_ud = 1'b0
);
  // One tick a cycle while running; count and direction move together
  always @(posedge clock) begin
    mode_ud <= updown;
    tick    <= run && !clr;
    if (clr) begin
      count <= 16'h0000;
      down  <= 1'b0;
    end else if (run && updown && down) begin
      // Turn back up on reaching zero
      count <= count - 16'h0001;
      down  <= (count != 16'h0001);
    end else if (run) begin
      // Turn round at the top value in up/down mode
      count <= count + 16'h0001;
      down  <= updown && (count + 16'h0001 == top);
    end
  end
endmodule  // tcc_timer_model
`default_nettype wire

// ### tb/test_timer_capcomp_ch0_ch1_dsm.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------
// Bench signals
// ----------------------------------------------------------
module test_timer_capcomp_ch0_ch1_dsm;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        run = 1'b0;
  logic        clr = 1'b0;
  logic        updown = 1'b0;
  logic [1:0]  capture_pin = 2'h0;
  logic [7:0]  radio_event = 8'h00;
  wire  [7:0]  reg_rdata_r;
  wire  [15:0] cnt, mod_sample_r, mod_rate_r;
  wire  [1:0]  chan_out_r, chan_irq_r;
  wire         tick, down, mode_ud, mod_sample_strobe_r, mod_interp_en_r, mod_shaping_en_r;
  wire         mod_active_r;
  int          bad_count = 0;
  int          samples_checked = 0;
  // Counter runs from 0 to 0x30 and back in up/down mode
  tcc_timer_model tcc_timer_model_i (.clock(clock), .run(run), .clr(clr), .updown(updown),
    .top(16'h0030), .count(cnt), .tick(tick), .down(down), .mode_ud(mode_ud));
  tcc_top tcc_top_i (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_r(reg_rdata_r), .timer_count(cnt), .timer_tick(tick), .timer_down(down),
    .timer_updown(mode_ud), .capture_pin(capture_pin), .radio_event(radio_event),
    .chan_out_r(chan_out_r), .chan_irq_r(chan_irq_r),
    .mod_sample_strobe_r(mod_sample_strobe_r), .mod_sample_r(mod_sample_r),
    .mod_rate_r(mod_rate_r), .mod_interp_en_r(mod_interp_en_r),
    .mod_shaping_en_r(mod_shaping_en_r), .mod_active_r(mod_active_r));
  always #10 clock = ~clock;
  // ----------------------------------------------------------
  // Compare, bus and timer helpers
  // ----------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk({8'h00, reg_rdata_r}, {8'h00, exp});
  endtask
  task automatic clr_timer;
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
  endtask
  // Run until the counter shows a value, then freeze and let outputs settle
  task automatic run_to(input logic [15:0] t, input logic dn);
    int n;
    n = 0;
    run <= 1'b1;
    while ((cnt !== t || down !== dn) && n < 400) begin
      @(posedge clock);
      #1 n++;
    end
    run <= 1'b0;
    chk1(n < 400, 1'b1);
    cyc(4);
  endtask
  // Request pulse may land in any of three cycles
  task automatic watch(input int ch, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (3) begin
      @(posedge clock);
      radio_event <= 8'h00;
      #1 seen = seen | chan_irq_r[ch];
    end
    chk1(seen, exp);
  endtask
  task automatic pin(input int ch, input logic lvl, input logic exp);
    @(posedge clock);
    capture_pin[ch] <= lvl;
    watch(ch, exp);
  endtask
  task automatic radio(input int b, input logic exp);
    @(posedge clock);
    radio_event <= 8'h01 << b;
    watch(0, exp);
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic reset_case;
    logic [7:0] a [8] = '{8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hE5, 8'hE6, 8'hE8, 8'h10};
    logic [7:0] v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h40, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) rdc(a[i], v[i]);
    wr(8'hDB, 8'h5A);
    rdc(8'hDB, 8'h5A);
    wr(8'hE5, 8'h9F);
    rdc(8'hE5, 8'h9F);
  endtask
  // Counter frozen at 0x0125 so the captured value is known
  task automatic capture_case;
    clr_timer();
    run_to(16'h0125, 1'b0);
    for (int e = 0; e < 4; e++) begin
      wr(8'hE5, 8'h40 | 8'(e));
      pin(0, 1'b1, e[0]);
      pin(0, 1'b0, e[1]);
    end
    rdc(8'hDA, 8'h25);
    rdc(8'hDB, 8'h01);
    wr(8'hE5, 8'h01);
    pin(0, 1'b1, 1'b0);
    pin(0, 1'b0, 1'b0);
    wr(8'hE8, 8'h04);
    wr(8'hE5, 8'hC1);
    radio(3, 1'b0);
    radio(2, 1'b1);
    wr(8'hE6, 8'h41);
    pin(1, 1'b1, 1'b1);
    pin(1, 1'b0, 1'b0);
  endtask
  task automatic cmp(input logic [2:0] act, input logic [15:0] t1, input logic d1,
                     input logic e1, input logic [15:0] t2, input logic d2, input logic e2);
    wr(8'hE6, {2'b01, act, 3'b100});
    clr_timer();
    run_to(t1, d1);
    chk1(chan_out_r[1], e1);
    if (t2 != 16'h0000) begin
      run_to(t2, d2);
      chk1(chan_out_r[1], e2);
    end
  endtask
  // Channel 0 at 0x20, channel 1 at 0x10, up/down counting
  task automatic compare_case;
    wr(8'hE5, 8'h44);
    wr(8'hDA, 8'h20);
    wr(8'hDB, 8'h00);
    wr(8'hDC, 8'h10);
    wr(8'hDD, 8'h00);
    updown <= 1'b1;
    cmp(3'h0, 16'h18, 1'b0, 1'b1, 16'h0, 1'b0, 1'b0);
    cmp(3'h1, 16'h18, 1'b0, 1'b0, 16'h0, 1'b0, 1'b0);
    cmp(3'h2, 16'h18, 1'b0, 1'b1, 16'h0, 1'b0, 1'b0);
    cmp(3'h3, 16'h18, 1'b0, 1'b1, 16'h08, 1'b1, 1'b0);
    cmp(3'h4, 16'h18, 1'b0, 1'b0, 16'h08, 1'b1, 1'b1);
    cmp(3'h5, 16'h18, 1'b0, 1'b1, 16'h28, 1'b0, 1'b0);
    cmp(3'h6, 16'h18, 1'b0, 1'b0, 16'h28, 1'b0, 1'b1);
    chk1(chan_out_r[0], 1'b1);
    rdc(8'hE9, 8'h03);
    updown <= 1'b0;
  endtask
  // Spacing of modulator steps in timer ticks
  task automatic speed(input logic s, input int p);
    int n;
    wr(8'hE6, {5'b01111, s, 2'b00});
    run <= 1'b1;
    n = 0;
    while (mod_active_r !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    n = 0;
    do begin
      @(posedge clock);
      #1 n++;
    end while (mod_active_r !== 1'b1 && n < 20);
    run <= 1'b0;
    chk({8'h00, 8'(n)}, {8'h00, 8'(p)});
  endtask
  task automatic mod_case;
    wr(8'hDB, 8'h01);
    wr(8'hE6, 8'h78);
    wr(8'hDC, 8'h37);
    wr(8'hDD, 8'h9A);
    cyc(2);
    chk(mod_sample_r, 16'h9A34);
    chk(mod_rate_r, 16'h0120);
    for (int c = 0; c < 4; c++) begin
      wr(8'hE6, 8'h78 | 8'(c));
      cyc(2);
      chk1(mod_interp_en_r, !c[1]);
      chk1(mod_shaping_en_r, !c[0]);
    end
    speed(1'b0, 8);
    speed(1'b1, 4);
  endtask
  // ----------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------
  task automatic results;
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    cyc(3);
    reset_case();
    capture_case();
    compare_case();
    mod_case();
    results();
  end
  // About a thousand cycles are expected; this cuts a hang short
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule  // test_timer_capcomp_ch0_ch1_dsm
`default_nettype wire
